/* File: conn_entry_decode.sv */
// Decoder of one connection memory entry into a routing decision
`timescale 1ns/1ps
module conn_entry_decode (
  input wire logic [switch_pkg::DATA_W-1:0] entry_i,
  input wire logic out_global_en_i,
  output switch_pkg::route_s route_o
);
  import switch_pkg::*;

  // ****************************************************************
  // Field extraction
  // ****************************************************************
  wire mode_hi = entry_i[CM_MODE_HI_BIT];
  wire mode_lo = entry_i[CM_MODE_LO_BIT];
  wire ch_en = entry_i[CM_CH_EN_BIT];

  // Mode selection and data path choice
  always_comb begin
    route_o = '0;
    route_o.src_stream = entry_i[STREAM_LSB +: STREAM_W];
    route_o.src_channel = entry_i[CHAN_W-1:0];
    route_o.msg_byte = entry_i[MSG_W-1:0];
    route_o.drive_en = out_global_en_i & ch_en;
    unique case ({mode_hi, mode_lo})
      2'b00: begin
        route_o.mode = MODE_VARIABLE;
        route_o.use_source = 1'b1;
      end
      2'b10: begin
        route_o.mode = MODE_CONSTANT;
        route_o.use_source = 1'b1;
      end
      2'b01: begin
        route_o.mode = MODE_MESSAGE;
        route_o.use_message = 1'b1;
      end
      2'b11: begin
        route_o.mode = MODE_TEST;
        route_o.use_pattern = 1'b1;
      end
    endcase
  end

endmodule // conn_entry_decode

/* File: host_bus_model.sv */
// Host processor model driving the microport pins
`timescale 1ns/1ps
module host_bus_model (
  input wire logic ref_clk_i,
  input wire logic ack_oe_i,
  output logic cs_n_o,
  output logic ds_n_o,
  output logic rd_wr_n_o,
  output logic [13:0] addr_o,
  output logic [15:0] data_o,
  output logic hang_o
);
  // Idle bus at time zero
  initial begin
    cs_n_o = 1'b1;
    ds_n_o = 1'b1;
    rd_wr_n_o = 1'b1;
    addr_o = 14'h0000;
    data_o = 16'h0000;
    hang_o = 1'b0;
  end
  // One transfer: hold until acknowledged, then release and keep a gap
  task automatic access(input logic rd, input logic [13:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    #1;
    cs_n_o = 1'b0;
    ds_n_o = 1'b0;
    rd_wr_n_o = rd;
    addr_o = a;
    data_o = d;
    while (ack_oe_i !== 1'b1 && n < 20) begin
      @(negedge ref_clk_i);
      n++;
    end
    @(posedge ref_clk_i);
    #1;
    cs_n_o = 1'b1;
    ds_n_o = 1'b1;
    addr_o = ~a; // Released lines carry no stale value
    data_o = ~d;
    while (ack_oe_i !== 1'b0 && n < 40) begin
      @(negedge ref_clk_i);
      n++;
    end
    if (n >= 20) hang_o = 1'b1;
    repeat (3) @(posedge ref_clk_i);
  endtask
endmodule // host_bus_model

/* File: switch_microport_checker.sv */
// Assertion checker for the switch microport control ports
`timescale 1ns/1ps
module switch_microport_checker (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic cs_n_i,
  input wire logic ds_n_i,
  input wire logic rd_wr_n_i,
  input wire logic [13:0] addr_i,
  input wire logic data_oe_o,
  input wire logic transfer_acknowledge_o,
  input wire logic transfer_acknowledge_oe_o,
  input wire logic [12:0] dm_addr_o,
  input wire logic clock_input_select_o,
  input wire logic error_count_clear_o,
  input wire logic error_test_start_o,
  input wire logic error_test_run_o,
  input wire logic block_fill_busy_o
);
  logic [12:0] fill_cnt_r;
  // ********
  // Helpers
  // ********
  // Cycles spent in the current block fill
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) fill_cnt_r <= 13'h0000;
    else if (block_fill_busy_o) fill_cnt_r <= fill_cnt_r + 13'h0001;
    else fill_cnt_r <= 13'h0000;
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Acknowledge rising, and the write phase that follows it
  sequence taken_s;
    $rose(transfer_acknowledge_oe_o);
  endsequence
  sequence wr_phase_s;
    transfer_acknowledge_oe_o && !data_oe_o;
  endsequence
  // ********
  // Assertions
  // ********
  AST_ACK_CAUSE: assert property (taken_s |-> !$past(cs_n_i, 2) && !$past(ds_n_i, 2))
    else $error("ack rose without a held strobe");
  AST_ACK_HOLD: assert property (transfer_acknowledge_oe_o && !ds_n_i |=> transfer_acknowledge_oe_o)
    else $error("ack dropped while strobe held");
  AST_ACK_RELEASE: assert property ($rose(ds_n_i) |-> ##[1:4] !transfer_acknowledge_oe_o)
    else $error("ack not released after strobe");
  AST_ACK_LOW: assert property (transfer_acknowledge_oe_o |-> !transfer_acknowledge_o)
    else $error("ack pin driven high");
  AST_READ_OE: assert property (taken_s |-> data_oe_o == $past(rd_wr_n_i, 2))
    else $error("data drive does not follow direction");
  AST_CLEAR_PULSE: assert property (error_count_clear_o |-> wr_phase_s ##1 !error_count_clear_o)
    else $error("error clear pulse misplaced");
  AST_START_PULSE: assert property (error_test_start_o |-> wr_phase_s ##1 error_test_run_o)
    else $error("error start pulse misplaced");
  AST_RUN_LEVEL: assert property ($changed(error_test_run_o) |-> wr_phase_s)
    else $error("error test run changed outside a write");
  AST_CLKSEL: assert property ($changed(clock_input_select_o) |-> wr_phase_s)
    else $error("clock select changed outside a write");
  AST_DM_INDEX: assert property ($changed(dm_addr_o) |-> dm_addr_o == addr_i[12:0] && addr_i[13])
    else $error("data memory index wrong");
  AST_FILL_LEN: assert property ($fell(block_fill_busy_o) |-> fill_cnt_r inside {[13'h0FFF:13'h1001]})
    else $error("block fill length wrong");
  AST_FILL_BOUND: assert property (block_fill_busy_o |-> fill_cnt_r < 13'h1388)
    else $error("block fill beyond two frames");
endmodule // switch_microport_checker

bind switch_microport_control switch_microport_checker u_switch_microport_checker (
  .ref_clk_i, .rst_n_i, .cs_n_i, .ds_n_i, .rd_wr_n_i, .addr_i, .data_oe_o,
  .transfer_acknowledge_o, .transfer_acknowledge_oe_o, .dm_addr_o, .clock_input_select_o,
  .error_count_clear_o, .error_test_start_o, .error_test_run_o, .block_fill_busy_o);

/* File: switch_microport_control.sv */
// Microport control: bus handshake, control register, memory access and block fill
`timescale 1ns/1ps
module switch_microport_control (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Host bus pins
  input wire logic cs_n_i,
  input wire logic ds_n_i,
  input wire logic rd_wr_n_i,
  input wire logic [switch_pkg::ADDR_W-1:0] addr_i,
  input wire logic [switch_pkg::DATA_W-1:0] data_i,
  output logic [switch_pkg::DATA_W-1:0] data_o,
  output logic data_oe_o,
  output logic transfer_acknowledge_o,
  output logic transfer_acknowledge_oe_o,
  input wire logic output_drive_enable_i,
  // Data memory read port
  output logic [switch_pkg::CM_IDX_W-1:0] dm_addr_o,
  input wire logic [switch_pkg::DATA_W-1:0] dm_rd_data_i,
  // Output engine lookup port
  input wire logic [switch_pkg::CM_IDX_W-1:0] eng_idx_i,
  output switch_pkg::route_s route_o,
  // Control fields for the rest of the device
  output logic [2:0] serial_rate_select_o,
  output logic clock_input_select_o,
  output logic frame_eval_start_o,
  output logic error_count_clear_o,
  output logic error_test_start_o,
  output logic error_test_run_o,
  output logic block_fill_busy_o
);
  import switch_pkg::*;

  typedef enum logic {
    BUS_IDLE,
    BUS_ACK
  } bus_state_e;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [SYNC_W-1:0] pin_meta_r;
  logic [SYNC_W-1:0] pin_sync_r;
  wire [SYNC_W-1:0] pin_raw = {cs_n_i, ds_n_i, rd_wr_n_i, addr_i, data_i,
                               output_drive_enable_i};

  // Two flops on every host pin; reset to idle so no false strobe follows reset
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_meta_r <= PIN_IDLE;
      pin_sync_r <= PIN_IDLE;
    end else begin
      pin_meta_r <= pin_raw;
      pin_sync_r <= pin_meta_r;
    end
  end

  // Synchronised pin fields
  wire s_cs_n = pin_sync_r[SYNC_W-1];
  wire s_ds_n = pin_sync_r[SYNC_W-2];
  wire s_rd = pin_sync_r[SYNC_W-3];
  wire [ADDR_W-1:0] s_addr = pin_sync_r[DATA_W+1 +: ADDR_W];
  wire [DATA_W-1:0] s_wdata = pin_sync_r[1 +: DATA_W];
  wire s_ode = pin_sync_r[0];

  // ****************************************************************
  // Address decode
  // ****************************************************************
  bus_state_e bus_state_r;
  bus_state_e bus_state_nxt;
  ctrl_s ctrl_r;
  ctrl_s ctrl_nxt;

  wire strobe = ~s_cs_n & ~s_ds_n;
  wire access = strobe & (bus_state_r == BUS_IDLE);
  wire mem_space = s_addr[ADDR_SPACE_BIT];
  wire reg_space = ~s_addr[ADDR_SPACE_BIT];
  wire [CM_IDX_W-1:0] mem_idx = {s_addr[STREAM_LSB +: STREAM_W], s_addr[CHAN_W-1:0]};
  wire is_ctrl = reg_space & (s_addr[12:0] == REG_SWITCH_CONTROL);
  wire wr_ctrl = access & ~s_rd & is_ctrl;
  wire rd_dm = access & s_rd & mem_space & ctrl_r.memory_select;
  wire rd_cm = access & s_rd & mem_space & ~ctrl_r.memory_select;
  wire wr_cm = access & ~s_rd & mem_space;

  // ****************************************************************
  // Control register
  // ****************************************************************
  logic fill_run_r;
  logic fill_run_nxt;
  logic [11:0] fill_idx_r;
  wire fill_done = fill_run_r & (fill_idx_r == FILL_LAST);
  ctrl_s ctrl_wr;
  assign ctrl_wr = ctrl_s'(s_wdata);
  wire fill_start = wr_ctrl & ctrl_wr.block_fill_go & ~ctrl_r.block_fill_go
                    & ctrl_wr.block_fill_arm;
  wire fill_abort = wr_ctrl & ~(ctrl_wr.block_fill_go & ctrl_wr.block_fill_arm);
  wire clr_rise = wr_ctrl & ctrl_wr.error_count_clear & ~ctrl_r.error_count_clear;
  wire start_rise = wr_ctrl & ctrl_wr.error_test_start & ~ctrl_r.error_test_start;

  // Next control value; fill go drops when the fill ends or never began
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_ctrl) begin
      ctrl_nxt = ctrl_wr;
      if (!ctrl_wr.block_fill_arm || !fill_start && (!ctrl_r.block_fill_go || fill_done)) begin
        ctrl_nxt.block_fill_go = 1'b0;
      end
    end else if (fill_done) begin
      ctrl_nxt.block_fill_go = 1'b0;
    end
  end

  // Fill run state
  always_comb begin
    fill_run_nxt = fill_run_r;
    if (fill_start) begin
      fill_run_nxt = 1'b1;
    end else if (fill_abort || fill_done) begin
      fill_run_nxt = 1'b0;
    end
  end

  // Control register and fill counter flops
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_r <= ctrl_s'(CTRL_RESET);
      fill_run_r <= 1'b0;
      fill_idx_r <= '0;
    end else begin
      ctrl_r <= ctrl_nxt;
      fill_run_r <= fill_run_nxt;
      fill_idx_r <= (fill_start || !fill_run_r) ? '0 : fill_idx_r + 12'h001;
    end
  end

  // ****************************************************************
  // Connection memory
  // ****************************************************************
  logic [DATA_W-1:0] conn_mem [0:CM_DEPTH-1];
  wire [DATA_W-1:0] fill_word = {ctrl_r.block_fill_value, 13'h0000};
  wire [CM_IDX_W-1:0] fill_even = {fill_idx_r, 1'b0};
  wire [CM_IDX_W-1:0] fill_odd = {fill_idx_r, 1'b1};

  // Block fill writes two entries a cycle so it ends inside two frames
  always_ff @(posedge ref_clk_i) begin
    if (fill_run_r) begin
      conn_mem[fill_even] <= fill_word;
      conn_mem[fill_odd] <= fill_word;
    end else if (wr_cm) begin
      conn_mem[mem_idx] <= s_wdata;
    end
  end

  // ****************************************************************
  // Bus handshake and read data
  // ****************************************************************
  logic [DATA_W-1:0] rdata_nxt;
  logic [DATA_W-1:0] data_r;
  logic data_oe_r;
  logic ack_oe_r;
  logic [DATA_W-1:0] dm_hold_r;
  logic [CM_IDX_W-1:0] dm_addr_r;

  // Read data source
  always_comb begin
    rdata_nxt = data_r;
    if (rd_dm) begin
      rdata_nxt = dm_hold_r;
    end else if (rd_cm) begin
      rdata_nxt = conn_mem[mem_idx];
    end else if (access && s_rd) begin
      rdata_nxt = is_ctrl ? DATA_W'(ctrl_r) : '0;
    end
  end

  // Acknowledge on access, release after the strobe ends
  always_comb begin
    bus_state_nxt = bus_state_r;
    unique case (bus_state_r)
      BUS_IDLE: if (access) bus_state_nxt = BUS_ACK;
      BUS_ACK: if (!strobe) bus_state_nxt = BUS_IDLE;
    endcase
  end

  // Bus outputs
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus_state_r <= BUS_IDLE;
      data_r <= '0;
      data_oe_r <= 1'b0;
      ack_oe_r <= 1'b0;
    end else begin
      bus_state_r <= bus_state_nxt;
      data_r <= rdata_nxt;
      ack_oe_r <= (bus_state_nxt == BUS_ACK);
      data_oe_r <= (bus_state_nxt == BUS_ACK) & s_rd;
    end
  end

  // Data memory address follows each data memory read; value held for the next read
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dm_addr_r <= '0;
      dm_hold_r <= '0;
    end else begin
      if (rd_dm) begin
        dm_addr_r <= mem_idx;
      end
      dm_hold_r <= dm_rd_data_i;
    end
  end

  // ****************************************************************
  // Output engine lookup
  // ****************************************************************
  logic [DATA_W-1:0] eng_entry_r;
  route_s route_nxt;
  route_s route_r;
  wire out_global_en = ctrl_r.output_standby | s_ode;

  // Entry read for the engine
  always_ff @(posedge ref_clk_i) begin
    eng_entry_r <= conn_mem[eng_idx_i];
  end

  conn_entry_decode u_decode (
    .entry_i(eng_entry_r),
    .out_global_en_i(out_global_en),
    .route_o(route_nxt)
  );

  // Event pulses and registered route
  logic err_clr_r;
  logic err_start_r;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      route_r <= '0;
      err_clr_r <= 1'b0;
      err_start_r <= 1'b0;
    end else begin
      route_r <= route_nxt;
      err_clr_r <= clr_rise;
      err_start_r <= start_rise;
    end
  end

  // ****************************************************************
  // Output assignments
  // ****************************************************************
  assign data_o = data_r;
  assign data_oe_o = data_oe_r;
  assign transfer_acknowledge_o = 1'b0; // Driven low only while enabled
  assign transfer_acknowledge_oe_o = ack_oe_r;
  assign dm_addr_o = dm_addr_r;
  assign route_o = route_r;
  assign serial_rate_select_o = ctrl_r.serial_rate_select;
  assign clock_input_select_o = ctrl_r.clock_input_select;
  assign frame_eval_start_o = ctrl_r.frame_eval_start;
  assign error_count_clear_o = err_clr_r;
  assign error_test_start_o = err_start_r;
  assign error_test_run_o = ctrl_r.error_test_start;
  assign block_fill_busy_o = fill_run_r;

endmodule // switch_microport_control

/* File: switch_pkg.sv */
// Constants, field layouts and carrier types for the switch microport control
// How it works
// - With A13 low, address bits A12..A0 select an internal register.
// - With A13 high, the address picks a data or connection memory location.
// - Data memory reads index input streams; connection memory writes index output streams.
// - Memory space: stream from A12..A8, channel from A7..A0.
// - All channels 0 to 255 of every stream are mapped for 16 Mb/s.
// - Low mode bit 0: switch the entry's source stream and channel to the output.
// - Mode high 0, low 1: send the entry's low eight bits as a message.
// - Both mode bits 1: send the pseudo-random test pattern.
// - Acknowledge pin driven low at transfer completion, released when the cycle ends.
// - Block fill loads fill value into entry bits 15..13 and clears 12..0.
// - Control bit 11 selects the expected input clock frequency.
// - Rising control bit 10 clears the error counter and error count register.
// - Rising bit 9 starts the error test; falling bit 9 stops it.
// - Memory select 0: connection memory; 1: reads data memory, writes connection memory.
// - Data memory read needs two cycles at one address; second returns valid data.
// - Rising fill go with fill arm set starts block fill, done within two frames, then go clears itself.
// - Outputs enabled by standby bit or drive pin with channel enable; else tristate.
package switch_pkg;

  // ****************************************************************
  // Bus and memory geometry
  // ****************************************************************
  localparam int ADDR_W = 14;
  localparam int DATA_W = 16;
  localparam int STREAM_W = 5;
  localparam int CHAN_W = 8;
  localparam int CM_IDX_W = STREAM_W + CHAN_W;
  localparam int CM_DEPTH = 8192;
  localparam int ADDR_SPACE_BIT = 13;
  localparam int STREAM_LSB = 8;
  localparam logic [12:0] REG_SWITCH_CONTROL = 13'h0000;
  localparam logic [15:0] CTRL_RESET = 16'h0000;

  // ****************************************************************
  // Connection memory entry layout
  // ****************************************************************
  localparam int CM_CH_EN_BIT = 15;
  localparam int CM_MODE_HI_BIT = 14;
  localparam int CM_MODE_LO_BIT = 13;
  localparam int CM_FILL_LSB = 13;
  localparam int MSG_W = 8;

  // ****************************************************************
  // Block fill timing
  // ****************************************************************
  localparam int FRAME_TIME_NS = 125000;
  localparam int CLK_PERIOD_NS = 50;
  localparam int FRAME_CYCLES = FRAME_TIME_NS / CLK_PERIOD_NS;
  localparam int FILL_STEPS = CM_DEPTH / 2;
  localparam logic [11:0] FILL_LAST = 12'hFFF;
  localparam int SYNC_W = 2 + 1 + ADDR_W + DATA_W + 1;
  // Synchroniser reset value: strobes and direction at their idle high level
  localparam logic [SYNC_W-1:0] PIN_IDLE = {3'b111, {(SYNC_W-3){1'b0}}};

  // Control register fields, bit 15 first
  typedef struct packed {
    logic [2:0] block_fill_value;
    logic unused12;
    logic clock_input_select;
    logic error_count_clear;
    logic error_test_start;
    logic frame_eval_start;
    logic unused7;
    logic block_fill_go;
    logic block_fill_arm;
    logic memory_select;
    logic output_standby;
    logic [2:0] serial_rate_select;
  } ctrl_s;

  // Channel mode from the two mode bits
  typedef enum logic [1:0] {
    MODE_VARIABLE,
    MODE_CONSTANT,
    MODE_MESSAGE,
    MODE_TEST
  } chan_mode_e;

  // Routing decision for one output channel
  typedef struct packed {
    logic drive_en;
    chan_mode_e mode;
    logic use_source;
    logic use_message;
    logic use_pattern;
    logic [STREAM_W-1:0] src_stream;
    logic [CHAN_W-1:0] src_channel;
    logic [MSG_W-1:0] msg_byte;
  } route_s;

endpackage

/* File: tb_switch_microport_control.sv */
// Testbench of the switch microport control block
`timescale 1ns/1ps
module tb_switch_microport_control;
  import switch_pkg::*;
  logic clk, rst_n, cs_n, ds_n, rd_wr_n, pin_oe, hang, data_oe, ack, ack_oe, prev_ack;
  logic clksel, fes, eclr, estart, erun, busy;
  logic [13:0] addr;
  logic [15:0] wdata, rdata, dm_rd, v;
  logic [15:0] ent[4];
  logic [12:0] dm_addr, eng_idx;
  logic [12:0] ix[4];
  logic [2:0] rate;
  logic [31:0] note;
  logic [31:0] exp_q[$];
  route_s route;
  integer bad_count = 0;
  integer samples_checked = 0;
  integer seed = 44;
  int n;
  int pulses = 0;
  // Clock
  initial clk = 1'b0;
  always #25 clk = ~clk;
  // Data memory stand-in answering its index at once
  assign dm_rd = {3'h6, dm_addr};
  switch_microport_control u_switch_microport_control (.ref_clk_i(clk), .rst_n_i(rst_n),
    .cs_n_i(cs_n), .ds_n_i(ds_n), .rd_wr_n_i(rd_wr_n), .addr_i(addr), .data_i(wdata),
    .data_o(rdata), .data_oe_o(data_oe), .transfer_acknowledge_o(ack),
    .transfer_acknowledge_oe_o(ack_oe), .output_drive_enable_i(pin_oe), .dm_addr_o(dm_addr),
    .dm_rd_data_i(dm_rd), .eng_idx_i(eng_idx), .route_o(route), .serial_rate_select_o(rate),
    .clock_input_select_o(clksel), .frame_eval_start_o(fes), .error_count_clear_o(eclr),
    .error_test_start_o(estart), .error_test_run_o(erun), .block_fill_busy_o(busy));
  host_bus_model u_host_bus_model (.ref_clk_i(clk), .ack_oe_i(ack_oe), .cs_n_o(cs_n),
    .ds_n_o(ds_n), .rd_wr_n_o(rd_wr_n), .addr_o(addr), .data_o(wdata), .hang_o(hang));
  // ********
  // Tasks
  // ********
  task report_and_stop;
    if (bad_count == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task compare_read(input logic [15:0] g, input logic [15:0] e, input logic [15:0] m);
    samples_checked++;
    if ((g & m) !== (e & m)) begin
      bad_count++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task compare_level(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task compare_route(input route_s g, input route_s e, input logic [26:0] m);
    samples_checked++;
    if ((g & m) !== (e & m)) begin
      bad_count++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task wr(input logic [13:0] a, input logic [15:0] d);
    u_host_bus_model.access(1'b0, a, d);
  endtask
  task rd(input logic [13:0] a, input logic [15:0] e, input logic [15:0] m);
    exp_q.push_back({m, e});
    u_host_bus_model.access(1'b1, a, 16'h0000);
  endtask
  // Look up one entry and compare the routing decision
  task route_chk(input logic [12:0] idx, input logic [15:0] e, input logic drv);
    route_s x;
    x.drive_en = drv & e[15];
    x.mode = chan_mode_e'({e[13], e[14]});
    x.use_source = ~e[13];
    x.use_message = e[13] & ~e[14];
    x.use_pattern = e[13] & e[14];
    x.src_stream = e[12:8];
    x.src_channel = e[7:0];
    x.msg_byte = e[7:0];
    @(posedge clk);
    #1;
    eng_idx = idx;
    repeat (3) @(posedge clk);
    @(negedge clk);
    compare_route(route, x, {6'h3F, {13{x.use_source}}, {8{x.use_message}}});
  endtask
  // ********
  // Result watcher and hang guard
  // ********
  always @(negedge clk) begin
    if (ack_oe === 1'b1 && data_oe === 1'b1 && prev_ack !== 1'b1) begin
      note = (exp_q.size() > 0) ? exp_q.pop_front() : {16'hFFFF, 16'hXXXX};
      compare_read(rdata, note[15:0], note[31:16]);
    end
    prev_ack = ack_oe;
  end
  // Count error clear and start pulses
  always @(posedge clk) begin
    pulses <= pulses + int'(eclr === 1'b1) + int'(estart === 1'b1);
  end
  always @(posedge hang) begin
    bad_count++;
    report_and_stop();
  end
  // ********
  // Main sequence
  // ********
  initial begin
    rst_n = 1'b0;
    pin_oe = 1'b0;
    eng_idx = 13'h0000;
    prev_ack = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    rst_n = 1'b1;
    wr(14'h0000, 16'h0000);
    rd(14'h0000, 16'h0000, 16'hFFFF);
    for (int i = 0; i < 6; i++) begin
      v = 16'($random(seed)) & 16'hEF3F;
      wr(14'h0000, v);
      compare_level({fes, clksel, erun, 10'h000, rate}, {v[8], v[11], v[9], 10'h000, v[2:0]});
      rd(14'h0000, v, 16'hFFFF);
    end
    wr(14'h0000, 16'h0000);
    n = pulses;
    wr(14'h0000, 16'h0600);
    compare_level(16'(pulses - n), 16'h0002);
    wr(14'h0000, 16'h0040);
    rd(14'h0000, 16'h0000, 16'hFFFF);
    wr(14'h0012, 16'hFFFF);
    rd(14'h0012, 16'h0000, 16'hFFFF);
    rd(14'h0000, 16'h0000, 16'hFFFF);
    for (int i = 0; i < 4; i++) begin
      ix[i] = (i == 3) ? 13'h1FFF : 13'($random(seed));
      if (i < 3) ix[i][12:11] = 2'(i);
      ent[i] = 16'($random(seed));
      ent[i][14:13] = 2'(i);
      wr({1'b1, ix[i]}, ent[i]);
      rd({1'b1, ix[i]}, ent[i], 16'hFFFF);
      route_chk(ix[i], ent[i], 1'b0);
    end
    @(posedge clk);
    #1;
    pin_oe = 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 4; i++) route_chk(ix[i], ent[i], 1'b1);
    @(posedge clk);
    #1;
    pin_oe = 1'b0;
    wr(14'h0000, 16'h0008);
    route_chk(ix[0], ent[0], 1'b1);
    wr(14'h0000, 16'h0010);
    v = 16'($random(seed));
    rd({1'b1, v[12:0]}, 16'h0000, 16'h0000);
    rd({1'b1, v[12:0]}, {3'h6, v[12:0]}, 16'hFFFF);
    wr({1'b1, v[12:0]}, 16'h1234);
    wr(14'h0000, 16'h0000);
    rd({1'b1, v[12:0]}, 16'h1234, 16'hFFFF);
    wr(14'h0000, 16'hA060);
    n = 0;
    while (busy !== 1'b0 && n < 6000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 6000) begin
      bad_count++;
      report_and_stop();
    end
    rd(14'h0000, 16'hA020, 16'hFFFF);
    rd({1'b1, ix[1]}, 16'hA000, 16'hFFFF);
    route_chk(ix[2], 16'hA000, 1'b0);
    repeat (4) @(posedge clk);
    if (exp_q.size() != 0) bad_count++;
    report_and_stop();
  end
endmodule // tb_switch_microport_control
